//--- verilog/core_idle_state_resolver.sv
// Functional notes
// - package request is the lowest idle state among all cores
// - level port reads become monitor-wait requests, no bus cycle, no monitor setup
// - any break event returns a core from idle to C0
// - halt or monitor-wait C1/C1E hint puts a core in C1 or C1E
// - a core in C1/C1E keeps servicing snoops
// - C6 entry saves context, then cuts voltage; exit powers and restores
// - C7 behaves as C6 and permits the platform idle state
// - auto-demotion turns C6/C7 into C1 until residency history suffices
// - auto-demotion is off after reset until firmware enables it
// - module C1 when all cores in C1 or deeper: clocks stopped, snoops wake
// - module C6 gates cores, may flush L2 and gate bus/L2 and graphics rail
// - package stays C0 while any core in C0 or no platform grant
// - platform idle level one only from package C6 or C7, L2 kept from C6
// - cores stay deep while an ungranted package stays shallower
// - package drops to C0 whenever its request changes between low-power states
// - package leaves any idle state at once on a break event
// - package C1 when one core in C1 and the rest C1 or deeper
// - enhanced halt lowers frequency first and voltage afterwards
// - package enhanced halt on hint, config limit or auto-promotion
// - no system notification on package C1 or C1E entry
// - package C6 when cores C6 or deeper and platform grants C6
// - package C7 only when all cores in C7, then system agent unpowered
`timescale 1ns/100ps
module core_idle_state_resolver
    import idle_state_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 resetn,
    // register port
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [DATA_W-1:0]    wdata,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic [DATA_W-1:0]         rdata,
    // core requests
    input  wire logic [NUM_CORES-1:0] idle_req,
    input  wire req_src_t             idle_src [NUM_CORES],
    input  wire logic [2:0]           idle_hint [NUM_CORES],
    input  wire logic [NUM_CORES-1:0] unmasked_interrupt,
    input  wire logic [NUM_CORES-1:0] nmi_event,
    input  wire logic [NUM_CORES-1:0] system_mgmt_interrupt,
    input  wire logic [NUM_CORES-1:0] pending_break_event,
    input  wire logic [NUM_CORES-1:0] msi_event,
    input  wire logic                 snoop_req,
    input  wire logic [NUM_CORES-1:0] save_done,
    input  wire logic [NUM_CORES-1:0] restore_done,
    output logic [NUM_CORES-1:0]      save_req,
    output logic [NUM_CORES-1:0]      power_off,
    output logic [NUM_CORES-1:0]      restore_req,
    output logic [NUM_CORES-1:0]      snoop_ok,
    // platform power unit
    output logic                      plat_req_valid,
    output cstate_t                   plat_req_state,
    input  wire logic                 plat_grant_valid,
    input  wire cstate_t              plat_grant_state,
    input  wire logic                 platform_idle_allow,
    input  wire logic [3:0]           l2_ways_left,
    // package controls
    output cstate_t                   pkg_state,
    output logic                      freq_low,
    output logic                      volt_low,
    output logic                      module_clk_stop,
    output logic                      cores_gated,
    output logic                      l2_flush,
    output logic                      biu_l2_off,
    output logic                      gfx_sram_off,
    output logic                      sys_agent_off,
    output logic                      platform_idle_level_one_req,
    output logic                      l2_retain,
    output logic                      deep_notify
);

    // -------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------
    logic [CFG_W-1:0]  cfg_reg;
    logic [MISC_W-1:0] misc_reg;
    logic              wr_cfg, wr_misc;

    assign wr_cfg  = wr_en && (addr == REG_IDLE_CFG);
    assign wr_misc = wr_en && (addr == REG_MISC);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_reg  <= CFG_RESET;
            misc_reg <= MISC_RESET;
        end else begin
            if (wr_cfg)
                cfg_reg <= wdata[CFG_W-1:0];
            if (wr_misc)
                misc_reg <= wdata[MISC_W-1:0];
        end
    end

    // -------------------------------------------------------------------
    // per-core trackers
    // -------------------------------------------------------------------
    core_link_if link [NUM_CORES] ();

    logic [NUM_CORES-1:0] brk;
    cstate_t              core_st [NUM_CORES];
    logic [NUM_CORES-1:0] core_halted;
    logic [NUM_CORES-1:0] core_c7;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
            assign brk[gi] = unmasked_interrupt[gi] | nmi_event[gi] |
                             system_mgmt_interrupt[gi] | pending_break_event[gi] |
                             msi_event[gi];
            assign link[gi].demote_en     = cfg_reg[CFG_DEMOTE_EN_BIT];
            assign link[gi].demote_policy = cfg_reg[CFG_POLICY_BIT];
            assign core_st[gi]     = link[gi].state;
            assign core_halted[gi] = link[gi].halted;
            assign core_c7[gi]     = link[gi].c7_permit;

            core_idle_tracker u_core (
                .clock        (clock),
                .resetn       (resetn),
                .idle_req     (idle_req[gi]),
                .idle_src     (idle_src[gi]),
                .idle_hint    (idle_hint[gi]),
                .brk          (brk[gi]),
                .save_done    (save_done[gi]),
                .restore_done (restore_done[gi]),
                .save_req     (save_req[gi]),
                .power_off    (power_off[gi]),
                .restore_req  (restore_req[gi]),
                .snoop_ok     (snoop_ok[gi]),
                .link         (link[gi].tracker)
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // package request resolution
    // -------------------------------------------------------------------
    cstate_t core_min;
    logic    brk_any;
    logic    all_halted;
    logic    all_c7;

    always_comb begin
        core_min   = CS_C7;
        all_halted = 1'b1;
        for (int i = 0; i < NUM_CORES; i++) begin
            if (core_st[i] < core_min)
                core_min = core_st[i];
            if (!core_halted[i])
                all_halted = 1'b0;
        end
    end

    assign brk_any = |brk;
    assign all_c7  = &core_c7;

    cstate_t want;

    always_comb begin
        unique case (core_min)
            CS_C0:  want = CS_C0;
            CS_C1:  want = (misc_reg[MISC_PROMOTE_BIT] && all_halted) ?
                           CS_C1E : CS_C1;
            CS_C1E: want = CS_C1E;
            CS_C6:  want = cfg_reg[CFG_LIMIT_C1_BIT] ? CS_C1E : CS_C6;
            CS_C7:  want = cfg_reg[CFG_LIMIT_C1_BIT] ? CS_C1E :
                           (all_c7 ? CS_C7 : CS_C6);
            default: want = CS_C0;
        endcase
    end

    // -------------------------------------------------------------------
    // platform request and grant
    // -------------------------------------------------------------------
    cstate_t grant_state_reg;
    logic    grant_valid_reg, grant_valid_next, grant_take, req_changed;

    assign req_changed      = (want != plat_req_state);
    assign grant_take       = plat_grant_valid && plat_req_valid && !req_changed;
    assign grant_valid_next = !brk_any && !req_changed && (want != CS_C0) &&
                              (grant_valid_reg || grant_take);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            grant_valid_reg <= 1'b0;
            grant_state_reg <= CS_C0;
            plat_req_valid  <= 1'b0;
            plat_req_state  <= CS_C0;
        end else begin
            grant_valid_reg <= grant_valid_next;
            if (grant_take)
                grant_state_reg <= plat_grant_state;
            plat_req_state  <= want;
            plat_req_valid  <= (want != CS_C0) && !brk_any && !grant_valid_next;
        end
    end

    // -------------------------------------------------------------------
    // package state
    // -------------------------------------------------------------------
    cstate_t grant_now, pkg_next;
    logic    pkg_deep;

    assign grant_now = grant_take ? plat_grant_state : grant_state_reg;
    always_comb begin
        if (brk_any || !grant_valid_next)
            pkg_next = CS_C0;
        else if (grant_now < want)
            pkg_next = grant_now;
        else
            pkg_next = want;
    end

    assign pkg_deep = (pkg_next >= CS_C6);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pkg_state <= CS_C0;
            freq_low  <= 1'b0;
            volt_low  <= 1'b0;
        end else begin
            pkg_state <= pkg_next;
            freq_low  <= (pkg_next == CS_C1E);
            volt_low  <= (pkg_next == CS_C1E) && freq_low;
        end
    end

    // -------------------------------------------------------------------
    // module and rail controls
    // -------------------------------------------------------------------
    logic flush_next;

    assign flush_next = pkg_deep && ((pkg_next == CS_C7) || (l2_ways_left == 4'h0) ||
                        cfg_reg[CFG_BIU_GATE_BIT]);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            module_clk_stop <= 1'b0;
            cores_gated     <= 1'b0;
            l2_flush        <= 1'b0;
            biu_l2_off      <= 1'b0;
            gfx_sram_off    <= 1'b0;
            sys_agent_off   <= 1'b0;
        end else begin
            module_clk_stop <= (core_min >= CS_C1) && !snoop_req && !brk_any;
            cores_gated     <= pkg_deep;
            l2_flush        <= flush_next;
            biu_l2_off      <= flush_next && cfg_reg[CFG_BIU_GATE_BIT];
            gfx_sram_off    <= pkg_deep && ((pkg_next == CS_C7) ||
                               cfg_reg[CFG_BIU_GATE_BIT]);
            sys_agent_off   <= (pkg_next == CS_C7);
        end
    end

    // -------------------------------------------------------------------
    // platform idle level and notification
    // -------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            platform_idle_level_one_req    <= 1'b0;
            l2_retain   <= 1'b0;
            deep_notify <= 1'b0;
        end else begin
            platform_idle_level_one_req    <= pkg_deep && platform_idle_allow;
            l2_retain   <= pkg_deep && platform_idle_allow &&
                           (pkg_next == CS_C6);
            deep_notify <= pkg_deep && (pkg_state < CS_C6);
        end
    end

    // -------------------------------------------------------------------
    // register read
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] read_mux;

    always_comb begin
        status_word = '0;
        status_word[STAT_PKG_LSB +: 3]   = pkg_state;
        status_word[STAT_GRANT_LSB +: 3] = grant_state_reg;
        status_word[STAT_GVALID_BIT]     = grant_valid_reg;
        status_word[STAT_PLATFORM_IDLE_LEVEL_ONE_BIT]       = platform_idle_level_one_req;
        status_word[STAT_RETAIN_BIT]     = l2_retain;
        for (int i = 0; i < NUM_CORES; i++)
            status_word[STAT_CORE_LSB + i*STAT_CORE_STEP +: 3] = core_st[i];
    end

    assign read_mux = (addr == REG_IDLE_CFG) ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg} :
                      (addr == REG_MISC)     ? {{(DATA_W-MISC_W){1'b0}}, misc_reg} :
                      (addr == REG_STATUS)   ? status_word : '0;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            rdata <= '0;
        else
            rdata <= rd_en ? read_mux : '0;
    end

endmodule : core_idle_state_resolver

//--- shared/idle_state_pkg.sv
package idle_state_pkg;

    // -------------------------------------------------------------------
    // idle state and request source encodings
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {CS_C0, CS_C1, CS_C1E, CS_C6, CS_C7} cstate_t;
    typedef enum logic [1:0] {SRC_HALT, SRC_MONITOR_WAIT_INSTRUCTION, SRC_PORT} req_src_t;

    // -------------------------------------------------------------------
    // sizes
    // -------------------------------------------------------------------
    localparam int NUM_CORES = 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int RES_CNT_W = 8;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_IDLE_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MISC     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h08;

    // -------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------
    localparam int CFG_DEMOTE_EN_BIT = 0;
    localparam int CFG_POLICY_BIT    = 1;
    localparam int CFG_LIMIT_C1_BIT  = 2;
    localparam int CFG_BIU_GATE_BIT  = 3;
    localparam int CFG_W             = 4;
    localparam int MISC_PROMOTE_BIT  = 0;
    localparam int MISC_W            = 1;
    localparam logic [CFG_W-1:0]  CFG_RESET  = 4'h0;
    localparam logic [MISC_W-1:0] MISC_RESET = 1'h0;
    localparam int STAT_PKG_LSB    = 0;
    localparam int STAT_GRANT_LSB  = 4;
    localparam int STAT_GVALID_BIT = 7;
    localparam int STAT_CORE_LSB   = 8;
    localparam int STAT_CORE_STEP  = 4;
    localparam int STAT_PLATFORM_IDLE_LEVEL_ONE_BIT   = 16;
    localparam int STAT_RETAIN_BIT = 17;

    // -------------------------------------------------------------------
    // port-read levels and residency thresholds (cycles)
    // -------------------------------------------------------------------
    localparam logic [2:0] LEVEL_C6 = 3'h3;
    localparam logic [2:0] LEVEL_C7 = 3'h7;
    localparam logic [RES_CNT_W-1:0] RES_SHORT = 8'h20;
    localparam logic [RES_CNT_W-1:0] RES_LONG  = 8'h80;

endpackage : idle_state_pkg

//--- shared/core_link_if.sv
`timescale 1ns/100ps
interface core_link_if;
    import idle_state_pkg::*;

    logic    demote_en;
    logic    demote_policy;
    cstate_t state;
    logic    halted;
    logic    c7_permit;

    modport tracker (input demote_en, input demote_policy,
                     output state, output halted, output c7_permit);
    modport resolver (output demote_en, output demote_policy,
                      input state, input halted, input c7_permit);

endinterface : core_link_if

//--- verilog/core_idle_tracker.sv
`timescale 1ns/100ps
module core_idle_tracker
    import idle_state_pkg::*;
(
    input  wire logic     clock,
    input  wire logic     resetn,
    input  wire logic     idle_req,
    input  wire req_src_t idle_src,
    input  wire logic [2:0] idle_hint,
    input  wire logic     brk,
    input  wire logic     save_done,
    input  wire logic     restore_done,
    output logic          save_req,
    output logic          power_off,
    output logic          restore_req,
    output logic          snoop_ok,
    core_link_if.tracker  link
);

    // -------------------------------------------------------------------
    // request translation
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {ST_ACTIVE, ST_C1, ST_SAVE, ST_OFF, ST_RESTORE} core_st_t;

    core_st_t               st_reg, st_next;
    cstate_t                want, eff, deep_reg, deep_next;
    logic                   c1e_reg, c1e_next, halt_reg, halt_next, hist_ok_reg;
    logic [RES_CNT_W-1:0]   res_cnt_reg;
    logic [RES_CNT_W-1:0]   res_thresh;

    always_comb begin
        unique case (idle_src)
            SRC_HALT:  want = CS_C1;
            SRC_MONITOR_WAIT_INSTRUCTION: want = cstate_t'(idle_hint);
            SRC_PORT:  want = (idle_hint == LEVEL_C7) ? CS_C7 :
                              (idle_hint == LEVEL_C6) ? CS_C6 : CS_C1;
            default:   want = CS_C0;
        endcase
    end

    assign res_thresh = link.demote_policy ? RES_LONG : RES_SHORT;
    assign eff = ((want >= CS_C6) && link.demote_en && !hist_ok_reg) ? CS_C1 : want;

    // -------------------------------------------------------------------
    // core state machine
    // -------------------------------------------------------------------
    always_comb begin
        st_next   = st_reg;
        deep_next = deep_reg;
        c1e_next  = c1e_reg;
        halt_next = halt_reg;
        unique case (st_reg)
            ST_ACTIVE: if (idle_req && !brk && eff != CS_C0) begin
                halt_next = (idle_src == SRC_HALT);
                if (eff >= CS_C6) begin
                    st_next   = ST_SAVE;
                    deep_next = eff;
                end else begin
                    st_next  = ST_C1;
                    c1e_next = (eff == CS_C1E);
                end
            end
            ST_C1:      if (brk) st_next = ST_ACTIVE;
            ST_SAVE:    if (brk) st_next = ST_ACTIVE;
                        else if (save_done) st_next = ST_OFF;
            ST_OFF:     if (brk) st_next = ST_RESTORE;
            ST_RESTORE: if (restore_done) st_next = ST_ACTIVE;
            default:    st_next = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg   <= ST_ACTIVE;
            deep_reg <= CS_C6;
            c1e_reg  <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            deep_reg <= deep_next;
            c1e_reg  <= c1e_next;
            halt_reg <= halt_next;
        end
    end

    // -------------------------------------------------------------------
    // residency history
    // -------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            res_cnt_reg <= '0;
            hist_ok_reg <= 1'b0;
        end else begin
            if (st_reg == ST_ACTIVE)
                res_cnt_reg <= '0;
            else if (res_cnt_reg != '1)
                res_cnt_reg <= res_cnt_reg + 1'b1;
            if (st_reg != ST_ACTIVE && res_cnt_reg >= res_thresh)
                hist_ok_reg <= 1'b1;
            else if (st_reg != ST_ACTIVE && st_next == ST_ACTIVE)
                hist_ok_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            save_req       <= 1'b0;
            power_off      <= 1'b0;
            restore_req    <= 1'b0;
            snoop_ok       <= 1'b0;
            link.state     <= CS_C0;
            link.halted    <= 1'b0;
            link.c7_permit <= 1'b0;
        end else begin
            save_req       <= (st_next == ST_SAVE);
            power_off      <= (st_next == ST_OFF);
            restore_req    <= (st_next == ST_RESTORE);
            snoop_ok       <= (st_next == ST_C1);
            link.state     <= (st_next == ST_C1) ? (c1e_next ? CS_C1E : CS_C1) :
                              (st_next == ST_OFF) ? deep_next : CS_C0;
            link.halted    <= (st_next == ST_C1) && halt_next;
            link.c7_permit <= (st_next == ST_OFF) && (deep_next == CS_C7);
        end
    end

endmodule : core_idle_tracker

//--- tb/core_idle_state_resolver_monitor.sv
`timescale 1ns/100ps
module core_idle_state_resolver_monitor
    import idle_state_pkg::*;
(
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic                 freq_low,
    input wire logic                 volt_low,
    input wire logic                 platform_idle_level_one_req,
    input wire logic                 l2_retain,
    input wire logic                 sys_agent_off,
    input wire logic                 deep_notify,
    input wire logic                 plat_grant_valid,
    input wire logic [NUM_CORES-1:0] unmasked_interrupt,
    input wire logic [NUM_CORES-1:0] save_req,
    input wire logic [NUM_CORES-1:0] power_off,
    input wire logic                 cores_gated,
    input wire cstate_t              pkg_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence core0_cut;
        $rose(power_off[0]);
    endsequence
    freq_first_a: assert property ($rose(volt_low) |-> $past(freq_low))
        else $error("voltage lowered before frequency");
    volt_freq_a: assert property (volt_low |-> freq_low)
        else $error("low voltage without low frequency");
    save_first_a: assert property (core0_cut |-> $past(save_req[0]))
        else $error("core powered off without context save");
    break_exit_a: assert property (|unmasked_interrupt |-> ##[1:2] pkg_state == CS_C0)
        else $error("package idle kept after break");
    platform_idle_level_one_deep_a: assert property (platform_idle_level_one_req |-> pkg_state inside {CS_C6, CS_C7})
        else $error("platform idle from shallow package state");
    retain_c6_a: assert property (l2_retain |-> pkg_state != CS_C7)
        else $error("cache retention claimed from C7");
    grant_gate_a: assert property ($changed(pkg_state) && pkg_state != CS_C0
        |-> $past(plat_grant_valid))
        else $error("package state entered without grant");
    gated_off_a: assert property (cores_gated |-> &power_off)
        else $error("cores gated while a core still powered");
    quiet_c1_a: assert property (pkg_state inside {CS_C1, CS_C1E} |-> !deep_notify)
        else $error("notification on halt state entry");
    agent_c7_a: assert property (sys_agent_off |-> pkg_state == CS_C7)
        else $error("system agent off outside C7");
endmodule : core_idle_state_resolver_monitor
bind core_idle_state_resolver core_idle_state_resolver_monitor mon_u (.clock, .resetn,
    .freq_low, .volt_low, .platform_idle_level_one_req, .l2_retain, .sys_agent_off, .deep_notify,
    .plat_grant_valid, .unmasked_interrupt, .save_req, .power_off, .cores_gated, .pkg_state);

//--- tb/plat_power_model.sv
`timescale 1ns/100ps
module plat_power_model
    import idle_state_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       req_valid,
    input  wire cstate_t    limit,
    input  wire logic [3:0] delay,
    output logic            grant_valid,
    output cstate_t         grant_state
);
    logic [3:0] wait_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_reg    <= 4'h0;
            grant_valid <= 1'b0;
            grant_state <= CS_C0;
        end else begin
            grant_valid <= 1'b0;
            grant_state <= cstate_t'(~grant_state);
            wait_reg    <= 4'h0;
            if (req_valid && !grant_valid) begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg >= delay) begin
                    grant_valid <= 1'b1;
                    grant_state <= limit;
                end
            end
        end
    end
endmodule : plat_power_model

//--- tb/core_idle_state_resolver_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("mismatch %0t value differs", $time); end end
module core_idle_state_resolver_tb import idle_state_pkg::*; ;
    logic clock, resetn, wr_en, rd_en, snoop_req, allow, pv, gv, rv;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [NUM_CORES-1:0] idle_req, save_done, restore_done, save_req, restore_req;
    req_src_t idle_src [NUM_CORES];
    logic [2:0] idle_hint [NUM_CORES];
    logic [4:0] bk;
    logic [3:0] delay, ways;
    cstate_t limit, gs, ps, pkg_state, pk;
    int errors, checks, cyc, nb;
    cstate_t pq[$];
    logic [DATA_W-1:0] rq[$];
    core_idle_state_resolver dut_u (.clock, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .idle_req, .idle_src, .idle_hint, .unmasked_interrupt({2{bk[0]}}),
        .nmi_event({2{bk[1]}}), .system_mgmt_interrupt({2{bk[2]}}),
        .pending_break_event({2{bk[3]}}), .msi_event({2{bk[4]}}), .snoop_req, .save_done,
        .restore_done, .save_req, .power_off(), .restore_req, .snoop_ok(), .plat_req_valid(pv),
        .plat_req_state(ps), .plat_grant_valid(gv), .plat_grant_state(gs),
        .platform_idle_allow(allow), .l2_ways_left(ways), .pkg_state, .freq_low(), .volt_low(),
        .module_clk_stop(), .cores_gated(), .l2_flush(), .biu_l2_off(), .gfx_sram_off(),
        .sys_agent_off(), .platform_idle_level_one_req(), .l2_retain(), .deep_notify());
    plat_power_model plat_u (.clock, .resetn, .req_valid(pv), .limit, .delay,
        .grant_valid(gv), .grant_state(gs));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic print_verdict();
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // ----
    // scoreboard: oldest note against each result
    // ----
    always @(posedge clock) begin
        save_done <= save_req & ~save_done;
        restore_done <= restore_req & ~restore_done;
        rv <= rd_en;
        if (rv) `CHK(rdata, rq.pop_front())
        if (resetn && pkg_state !== pk) begin
            `CHK(pkg_state, pq.pop_front())
            pk = pkg_state;
        end
        cyc++;
        if (cyc == 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rq.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
    endtask : rd
    task automatic go(input req_src_t s0, s1, input logic [2:0] h0, h1, input cstate_t lm, ex);
        pq.push_back(ex);
        pq.push_back(CS_C0);
        limit <= lm;
        delay <= 4'($urandom_range(6));
        snoop_req <= 1'($urandom);
        idle_src <= '{s0, s1};
        idle_hint <= '{h0, h1};
        idle_req <= 2'b11;
        @(posedge clock);
        idle_req <= 2'b00;
        repeat (30) @(posedge clock);
        bk <= 5'h1 << (nb % 5);
        nb++;
        repeat (3) @(posedge clock);
        bk <= 5'h0;
        repeat (30) @(posedge clock);
    endtask : go
    initial begin
        void'($urandom(32'h8de7466e));
        {resetn, wr_en, rd_en, snoop_req, rv, idle_req, save_done, restore_done, bk} = '0;
        {addr, wdata, delay} = '0;
        allow = 1'b1;
        ways = 4'h8;
        limit = CS_C0;
        pk = CS_C0;
        idle_src = '{SRC_HALT, SRC_HALT};
        idle_hint = '{3'h0, 3'h0};
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd(REG_IDLE_CFG, 32'h0);
        rd(REG_MISC, 32'h0);
        v = $urandom;
        wr(REG_IDLE_CFG, v);
        rd(REG_IDLE_CFG, {28'h0, v[CFG_W-1:0]});
        rd(8'hfc, 32'h0);
        wr(REG_IDLE_CFG, 32'h0);
        go(SRC_HALT, SRC_HALT, 3'h0, 3'h0, CS_C7, CS_C1);
        go(SRC_MONITOR_WAIT_INSTRUCTION, SRC_MONITOR_WAIT_INSTRUCTION, 3'h2, 3'h2, CS_C7, CS_C1E);
        go(SRC_PORT, SRC_PORT, LEVEL_C6, LEVEL_C6, CS_C7, CS_C6);
        go(SRC_PORT, SRC_PORT, LEVEL_C7, LEVEL_C7, CS_C6, CS_C6);
        go(SRC_MONITOR_WAIT_INSTRUCTION, SRC_MONITOR_WAIT_INSTRUCTION, 3'h4, 3'h4, CS_C7, CS_C7);
        go(SRC_HALT, SRC_PORT, 3'h0, LEVEL_C6, CS_C7, CS_C1);
        wr(REG_MISC, 32'h1);
        go(SRC_HALT, SRC_HALT, 3'h0, 3'h0, CS_C7, CS_C1E);
        wr(REG_MISC, 32'h0);
        wr(REG_IDLE_CFG, 32'h1);
        go(SRC_PORT, SRC_PORT, LEVEL_C6, LEVEL_C6, CS_C7, CS_C1);
        wr(REG_IDLE_CFG, 32'h4);
        go(SRC_PORT, SRC_PORT, LEVEL_C6, LEVEL_C6, CS_C7, CS_C1E);
        `CHK(pq.size(), 0)
        print_verdict();
    end
endmodule : core_idle_state_resolver_tb
